//--- core/dbt_core.sv
// Burst length selection, write/read latency and burst data engine.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
// How it works
// - A12 low chops a burst to four beats, high gives eight beats.
// - A12 only picks burst length and never forms part of the column.
// - Burst mode field 00 fixed eight, 01 per-command A12, 10 fixed four.
// - Bad data setup or hold corrupts only that burst; device keeps working.
// - Bad strobe timing corrupts only that burst's location; device never hangs.
// - One mask bit per data byte, timed like data, blocks that byte's write.
// - Mask ignored on reads; becomes termination strobe on writes when enabled.
// - Write data starts after write latency, additive plus CAS write latency.
// - Read drive ends at the rise RL+4 for eight beats, RL+2 chopped.
module dbt_core #(
	parameter int DEPTH = 64
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Command pins from the controller
	input wire logic ck,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [dbt_pkg::BA_W-1:0] ba,
	input wire logic [dbt_pkg::ADDR_W-1:0] addr,
	// Data pins
	input wire logic [dbt_pkg::DQ_W-1:0] dq_in,
	output logic [dbt_pkg::DQ_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic dqs_in,
	output logic dqs_out,
	output logic dqs_oe,
	// Mask pin, doubling as termination strobe
	input wire logic dm_in,
	output logic tdqs_out,
	output logic tdqs_oe,
	// Register port
	input wire logic [dbt_pkg::REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	localparam int IDX_W = $clog2(DEPTH);

	dbt_lnk_if lnk ();

	dbt_sync u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.pins({ck, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in, dm_in, dqs_in}),
		.lnk(lnk)
	);

	// Registered state.
	logic [31:0] ctrl;
	logic viol;
	logic [7:0] wr_cnt_done;
	logic [dbt_pkg::LAT_MAX-1:0] rd_pipe;
	logic [dbt_pkg::LAT_MAX-1:0] wr_pipe;
	logic [dbt_pkg::LAT_MAX-1:0] bl8_pipe;
	logic [dbt_pkg::COL_W-1:0] col_pipe [dbt_pkg::LAT_MAX];
	dbt_pkg::dbt_eng_t wr_st;
	logic [3:0] wr_beat;
	logic [3:0] wr_edges;
	logic [IDX_W-1:0] wr_base;
	logic wr_dqs_last;
	dbt_pkg::dbt_eng_t rd_st;
	logic [3:0] rd_beat;
	logic [3:0] rd_edges;
	logic [IDX_W-1:0] rd_base;
	logic [dbt_pkg::DQ_W-1:0] mem [DEPTH];

	// Next values.
	logic [31:0] next_ctrl;
	logic next_viol;
	logic [7:0] next_wr_cnt_done;
	logic [dbt_pkg::LAT_MAX-1:0] next_rd_pipe;
	logic [dbt_pkg::LAT_MAX-1:0] next_wr_pipe;
	logic [dbt_pkg::LAT_MAX-1:0] next_bl8_pipe;
	logic [dbt_pkg::COL_W-1:0] next_col_pipe [dbt_pkg::LAT_MAX];
	dbt_pkg::dbt_eng_t next_wr_st;
	logic [3:0] next_wr_beat;
	logic [3:0] next_wr_edges;
	logic [IDX_W-1:0] next_wr_base;
	logic next_wr_dqs_last;
	dbt_pkg::dbt_eng_t next_rd_st;
	logic [3:0] next_rd_beat;
	logic [3:0] next_rd_edges;
	logic [IDX_W-1:0] next_rd_base;
	logic [dbt_pkg::DQ_W-1:0] next_dq_out;
	logic next_dq_oe;
	logic next_dqs_out;
	logic next_tdqs_out;
	logic next_tdqs_oe;
	logic [31:0] next_reg_rdata;
	logic mem_we;
	logic [IDX_W-1:0] mem_idx;

	// Decoded configuration.
	logic [1:0] bm;
	logic tdqs_en;
	logic [dbt_pkg::LAT_W-1:0] cl;
	logic [dbt_pkg::LAT_W-1:0] cwl;
	logic [dbt_pkg::LAT_W-1:0] al;
	logic [dbt_pkg::LAT_W-1:0] rl;
	logic [dbt_pkg::LAT_W-1:0] wl;
	logic cmd_bl8;
	logic wr_start;
	logic rd_start;
	logic any_edge;

	always_comb begin
		bm = ctrl[dbt_pkg::CTRL_BM_LSB +: 2];
		tdqs_en = ctrl[dbt_pkg::CTRL_TDQS];
		cl = {1'b0, ctrl[dbt_pkg::CTRL_CL_LSB +: 4]};
		cwl = {1'b0, ctrl[dbt_pkg::CTRL_CWL_LSB +: 4]};
		case (ctrl[dbt_pkg::CTRL_AL_LSB +: 2])
			dbt_pkg::AL_CL1: al = cl - 5'd1;
			dbt_pkg::AL_CL2: al = cl - 5'd2;
			default: al = '0;
		endcase
		rl = al + cl;
		wl = al + cwl;
		case (bm)
			dbt_pkg::BM_FIXED8: cmd_bl8 = 1'b1;
			dbt_pkg::BM_OTF: cmd_bl8 = lnk.addr[dbt_pkg::BC_BIT];
			default: cmd_bl8 = 1'b0;
		endcase
		any_edge = lnk.ck_rise | lnk.ck_fall;
		wr_start = lnk.ck_rise & wr_pipe[wl - 5'd1];
		rd_start = lnk.ck_rise & rd_pipe[rl - 5'd1];
	end

	// Latency pipelines, one slot per link clock rise.
	always_comb begin
		next_rd_pipe = rd_pipe;
		next_wr_pipe = wr_pipe;
		next_bl8_pipe = bl8_pipe;
		next_col_pipe = col_pipe;
		if (lnk.ck_rise) begin
			next_rd_pipe = {rd_pipe[dbt_pkg::LAT_MAX-2:0], lnk.cmd_rd};
			next_wr_pipe = {wr_pipe[dbt_pkg::LAT_MAX-2:0], lnk.cmd_wr};
			next_bl8_pipe = {bl8_pipe[dbt_pkg::LAT_MAX-2:0], cmd_bl8};
			for (int k = dbt_pkg::LAT_MAX - 1; k > 0; k--) begin
				next_col_pipe[k] = col_pipe[k-1];
			end
			next_col_pipe[0] = lnk.addr[dbt_pkg::COL_W-1:0];
		end
	end

	// Write engine: beat 0 on the rise at WL, then one beat per link edge.
	always_comb begin
		next_wr_st = wr_st;
		next_wr_beat = wr_beat;
		next_wr_edges = wr_edges;
		next_wr_base = wr_base;
		next_wr_dqs_last = wr_dqs_last;
		next_viol = viol;
		next_wr_cnt_done = wr_cnt_done;
		mem_we = 1'b0;
		mem_idx = wr_base + IDX_W'(wr_beat);
		if (wr_start) begin
			next_wr_st = dbt_pkg::ENG_BURST;
			next_wr_base = col_pipe[wl - 5'd1][IDX_W-1:0];
			next_wr_edges = bl8_pipe[wl - 5'd1] ? dbt_pkg::BL8_EDGES : dbt_pkg::BC4_EDGES;
			next_wr_beat = 4'd1;
			next_wr_dqs_last = lnk.dqs;
			mem_idx = col_pipe[wl - 5'd1][IDX_W-1:0];
			mem_we = ~(lnk.dm & ~tdqs_en);
		end else if (wr_st == dbt_pkg::ENG_BURST && any_edge) begin
			// A strobe that failed to toggle is flagged; the beat is still stored.
			if (lnk.dqs == wr_dqs_last) begin
				next_viol = 1'b1;
			end
			next_wr_dqs_last = lnk.dqs;
			mem_we = ~(lnk.dm & ~tdqs_en);
			next_wr_beat = wr_beat + 4'd1;
			// The burst always closes by count, so a bad strobe cannot stall it.
			if (wr_beat + 4'd1 == wr_edges) begin
				next_wr_st = dbt_pkg::ENG_IDLE;
				next_wr_cnt_done = wr_cnt_done + 8'd1;
			end
		end
		if (reg_wr && reg_addr == dbt_pkg::REG_STAT && reg_wdata[dbt_pkg::STAT_VIOL]) begin
			// A violation caught in the clearing cycle survives the clear.
			next_viol = next_viol & (!wr_start && wr_st == dbt_pkg::ENG_BURST && any_edge
				&& lnk.dqs == wr_dqs_last);
		end
	end

	// Read engine: drive from the rise at RL until the rise at RL+4 or RL+2.
	always_comb begin
		next_rd_st = rd_st;
		next_rd_beat = rd_beat;
		next_rd_edges = rd_edges;
		next_rd_base = rd_base;
		next_dq_out = dq_out;
		next_dq_oe = dq_oe;
		next_dqs_out = dqs_out;
		if (rd_start) begin
			next_rd_st = dbt_pkg::ENG_BURST;
			next_rd_base = col_pipe[rl - 5'd1][IDX_W-1:0];
			next_rd_edges = bl8_pipe[rl - 5'd1] ? dbt_pkg::BL8_EDGES : dbt_pkg::BC4_EDGES;
			next_rd_beat = 4'd1;
			next_dq_out = mem[col_pipe[rl - 5'd1][IDX_W-1:0]];
			next_dq_oe = 1'b1;
			next_dqs_out = 1'b1;
		end else if (rd_st == dbt_pkg::ENG_BURST && any_edge) begin
			if (rd_beat == rd_edges) begin
				next_rd_st = dbt_pkg::ENG_IDLE;
				next_dq_oe = 1'b0;
				next_dqs_out = 1'b0;
			end else begin
				next_rd_beat = rd_beat + 4'd1;
				next_dq_out = mem[rd_base + IDX_W'(rd_beat)];
				next_dqs_out = ~dqs_out;
			end
		end
	end

	// Termination strobe output and register port.
	always_comb begin
		next_tdqs_oe = tdqs_en & (next_wr_st == dbt_pkg::ENG_BURST);
		next_tdqs_out = lnk.dqs;
		next_ctrl = ctrl;
		if (reg_wr && reg_addr == dbt_pkg::REG_CTRL) begin
			next_ctrl = reg_wdata;
		end
		next_reg_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				dbt_pkg::REG_CTRL: next_reg_rdata = ctrl;
				dbt_pkg::REG_STAT: begin
					next_reg_rdata[dbt_pkg::STAT_VIOL] = viol;
					next_reg_rdata[dbt_pkg::STAT_WR_BUSY] = wr_st == dbt_pkg::ENG_BURST;
					next_reg_rdata[dbt_pkg::STAT_RD_BUSY] = rd_st == dbt_pkg::ENG_BURST;
					next_reg_rdata[dbt_pkg::STAT_CNT_LSB +: 8] = wr_cnt_done;
				end
				default: next_reg_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= dbt_pkg::CTRL_RST;
			viol <= 1'b0;
			wr_cnt_done <= '0;
			rd_pipe <= '0;
			wr_pipe <= '0;
			bl8_pipe <= '0;
			col_pipe <= '{default: '0};
			wr_st <= dbt_pkg::ENG_IDLE;
			wr_beat <= '0;
			wr_edges <= '0;
			wr_base <= '0;
			wr_dqs_last <= 1'b0;
			rd_st <= dbt_pkg::ENG_IDLE;
			rd_beat <= '0;
			rd_edges <= '0;
			rd_base <= '0;
			dq_out <= '0;
			dq_oe <= 1'b0;
			dqs_out <= 1'b0;
			dqs_oe <= 1'b0;
			tdqs_out <= 1'b0;
			tdqs_oe <= 1'b0;
			reg_rdata <= '0;
		end else begin
			ctrl <= next_ctrl;
			viol <= next_viol;
			wr_cnt_done <= next_wr_cnt_done;
			rd_pipe <= next_rd_pipe;
			wr_pipe <= next_wr_pipe;
			bl8_pipe <= next_bl8_pipe;
			col_pipe <= next_col_pipe;
			wr_st <= next_wr_st;
			wr_beat <= next_wr_beat;
			wr_edges <= next_wr_edges;
			wr_base <= next_wr_base;
			wr_dqs_last <= next_wr_dqs_last;
			rd_st <= next_rd_st;
			rd_beat <= next_rd_beat;
			rd_edges <= next_rd_edges;
			rd_base <= next_rd_base;
			dq_out <= next_dq_out;
			dq_oe <= next_dq_oe;
			dqs_out <= next_dqs_out;
			dqs_oe <= next_dq_oe;
			tdqs_out <= next_tdqs_out;
			tdqs_oe <= next_tdqs_oe;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Data storage: flip-flops written one byte per accepted beat.
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_idx] <= lnk.dq;
		end
	end
endmodule // dbt_core

//--- core/dbt_sync.sv
// Two-stage synchroniser, link clock edge finder and command decoder.
`timescale 1ns/100ps
module dbt_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Raw pins: ck, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dm, dqs
	input wire logic [dbt_pkg::PIN_W-1:0] pins,
	// Sampled link
	dbt_lnk_if.src lnk
);
	logic [dbt_pkg::PIN_W-1:0] meta;
	logic [dbt_pkg::PIN_W-1:0] sync;
	logic ck_last;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;

	genvar i;
	generate
		for (i = 0; i < dbt_pkg::PIN_W; i++) begin : g_bit
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					meta[i] <= 1'b0;
					sync[i] <= 1'b0;
				end else begin
					meta[i] <= pins[i];
					sync[i] <= meta[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ck_last <= 1'b0;
		end else begin
			ck_last <= sync[dbt_pkg::PIN_W-1];
		end
	end

	assign {cs_n, ras_n, cas_n, we_n} = sync[dbt_pkg::PIN_W-2 -: 4];
	assign {lnk.ba, lnk.addr, lnk.dq, lnk.dm, lnk.dqs} = sync[dbt_pkg::PIN_W-6:0];
	assign lnk.ck_rise = sync[dbt_pkg::PIN_W-1] & ~ck_last;
	assign lnk.ck_fall = ~sync[dbt_pkg::PIN_W-1] & ck_last;
	// Commands are registered only on the rising link clock edge.
	assign lnk.cmd_rd = lnk.ck_rise & ~cs_n & ras_n & ~cas_n & we_n;
	assign lnk.cmd_wr = lnk.ck_rise & ~cs_n & ras_n & ~cas_n & ~we_n;
endmodule // dbt_sync

//--- dv/dbt_core_props.sv
// Port assertions for the burst timing core.
`timescale 1ns/100ps
module dbt_core_props (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Link and data enables
	input wire logic ck,
	input wire logic dq_oe,
	input wire logic dqs_oe,
	input wire logic tdqs_oe,
	// Register port
	input wire logic [dbt_pkg::REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data not idle");
	unmapped_rd_a: assert property ($past(reg_rd) && $past(reg_addr) != dbt_pkg::REG_CTRL
		&& $past(reg_addr) != dbt_pkg::REG_STAT |-> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	ctrl_readback_a: assert property ($past(reg_wr, 3) && !$past(reg_wr, 2) && $past(reg_rd)
		&& $past(reg_addr, 3) == dbt_pkg::REG_CTRL && $past(reg_addr) == dbt_pkg::REG_CTRL
		|-> reg_rdata[13:0] == $past(reg_wdata[13:0], 3)) else $error("control readback");
	strobe_oe_a: assert property (dqs_oe == dq_oe) else $error("strobe enable split");
	oe_rise_ck_a: assert property ($rose(dq_oe) |-> ck && !$past(ck, 8))
		else $error("drive start off link rise");
	oe_fall_ck_a: assert property ($fell(dq_oe) |-> ck && !$past(ck, 8))
		else $error("drive end off link rise");
	burst_len_a: assert property ($rose(dq_oe) |-> ##[62:130] $fell(dq_oe))
		else $error("read drive length");
	burst_min_a: assert property ($rose(dq_oe) |-> ##60 dq_oe) else $error("read cut short");
	tdqs_excl_a: assert property (tdqs_oe |-> !dq_oe) else $error("tdqs during read");
endmodule // dbt_core_props
bind dbt_core dbt_core_props dbt_core_props_inst (.clk, .arst_n, .ck, .dq_oe, .dqs_oe,
	.tdqs_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

//--- dv/dbt_core_test.sv
// Self-checking bench for the burst timing core.
`timescale 1ns/100ps
module dbt_core_test;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic ck, cs_n, ras_n, cas_n, we_n, dqs_in, dm_in, dq_oe, dqs_out, dqs_oe, tdqs_out, tdqs_oe;
	logic [2:0] ba;
	logic [13:0] addr;
	logic [7:0] dq_in, dq_out;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata, v;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tdqs_seen = 1'b0;
	logic [7:0] mem [64];
	logic [7:0] d [8];
	logic [9:0] s [9];
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int nwr = 0;
	dbt_core #(.DEPTH(64)) dbt_core_inst (.clk, .arst_n, .ck, .cs_n, .ras_n, .cas_n, .we_n,
		.ba, .addr, .dq_in, .dq_out, .dq_oe, .dqs_in, .dqs_out, .dqs_oe, .dm_in, .tdqs_out,
		.tdqs_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	dbt_ctl dbt_ctl_inst (.ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_in, .dqs_in,
		.dm_in, .dq_out, .dq_oe, .dqs_out);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (tdqs_oe === 1'b1) tdqs_seen <= 1'b1;
		if (cyc == 30000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rw(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rr(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	function automatic logic [13:0] adr(input int col, input logic a12);
		return {1'b0, a12, 2'h0, 10'(col)};
	endfunction
	task automatic put(input int wl, input int col, input logic a12, input int n,
		input logic [7:0] m, input logic bad, input logic masked);
		for (int i = 0; i < 8; i++) d[i] = 8'(col * 8 + i + nwr);
		dbt_ctl_inst.wr(wl, adr(col, a12), n, d, m, bad);
		for (int i = 0; i < n; i++) if (!(m[i] && masked)) mem[(col + i) % 64] = d[i];
		nwr++;
	endtask
	task automatic get(input int rl, input int col, input logic a12, input int n);
		dbt_ctl_inst.rd(rl, adr(col, a12), s);
		for (int i = 0; i < 9; i++)
			chk({22'h0, s[i]}, {22'h0, i < n && i % 2 == 0, i < n,
				mem[(col + (i < n ? i : n - 1)) % 64]});
	endtask
	task automatic t_regs();
		rr(dbt_pkg::REG_CTRL);
		chk(v, dbt_pkg::CTRL_RST);
		rw(8'h08, 32'hffff_ffff);
		rr(8'h08);
		chk(v, 32'h0000_0000);
		rw(dbt_pkg::REG_CTRL, 32'h0000_0551);
		rr(dbt_pkg::REG_CTRL);
		chk(v & 32'h0000_3ff7, 32'h0000_0551);
	endtask
	task automatic t_otf();
		put(5, 0, 1'b1, 8, 8'h00, 1'b0, 1'b1);
		put(5, 8, 1'b0, 4, 8'h00, 1'b0, 1'b1);
		get(5, 0, 1'b1, 8);
		get(5, 0, 1'b0, 4);
		get(5, 8, 1'b0, 4);
		put(5, 0, 1'b1, 8, 8'h24, 1'b0, 1'b1);
		get(5, 0, 1'b1, 8);
	endtask
	task automatic t_fixed();
		rw(dbt_pkg::REG_CTRL, 32'h0000_0550);
		put(5, 16, 1'b0, 8, 8'h00, 1'b0, 1'b1);
		get(5, 16, 1'b0, 8);
		rw(dbt_pkg::REG_CTRL, 32'h0000_0552);
		put(5, 16, 1'b1, 4, 8'h00, 1'b0, 1'b1);
		get(5, 16, 1'b1, 4);
	endtask
	task automatic t_lat();
		rw(dbt_pkg::REG_CTRL, 32'h0000_1551);
		put(9, 24, 1'b1, 8, 8'h00, 1'b0, 1'b1);
		rw(dbt_pkg::REG_CTRL, 32'h0000_2551);
		get(8, 24, 1'b1, 8);
	endtask
	task automatic t_viol();
		rw(dbt_pkg::REG_CTRL, 32'h0000_0551);
		put(5, 32, 1'b1, 8, 8'h00, 1'b1, 1'b1);
		rr(dbt_pkg::REG_STAT);
		chk(v & 32'h0000_ff07, {16'h0, 8'(nwr), 8'h01});
		rw(dbt_pkg::REG_STAT, 32'h0000_0001);
		rr(dbt_pkg::REG_STAT);
		chk(v & 32'h0000_0001, 32'h0000_0000);
		put(5, 40, 1'b1, 8, 8'h00, 1'b0, 1'b1);
		get(5, 40, 1'b1, 8);
	endtask
	task automatic t_tdqs();
		rw(dbt_pkg::REG_CTRL, 32'h0000_0555);
		put(5, 48, 1'b1, 8, 8'hff, 1'b0, 1'b0);
		get(5, 48, 1'b1, 8);
		chk({31'h0, tdqs_seen}, 32'h0000_0001);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_otf();
		t_fixed();
		t_lat();
		t_viol();
		t_tdqs();
		conclude();
	end
endmodule // dbt_core_test

//--- dv/dbt_ctl.sv
// Behavioural memory controller driving the link pins.
`timescale 1ns/100ps
module dbt_ctl (
	// Link clock and command
	output logic ck,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] ba,
	output logic [13:0] addr,
	// Data
	output logic [7:0] dq_in,
	output logic dqs_in,
	output logic dm_in,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe,
	input wire logic dqs_out
);
	initial begin
		{ck, ba, addr, dq_in, dqs_in, dm_in} = '0;
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
	end
	// The command clock runs free, out of phase with the system clock.
	initial #37 forever #80 ck = ~ck;
	// Only column commands are sent, so no row spacing is owed.
	task automatic cmd(input logic w, input logic [13:0] a);
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} = w ? 4'h4 : 4'h5;
		addr = a;
		ba = 3'h1;
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		addr = ~a;
	endtask
	task automatic wr(input int wl, input logic [13:0] a, input int n, input logic [7:0] d [8],
		input logic [7:0] m, input logic bad);
		cmd(1'b1, a);
		#(wl * 160 - 120);
		for (int i = 0; i < n; i++) begin
			dq_in = d[i];
			dm_in = m[i];
			dqs_in = (bad && i == 3) ? dqs_in : ~i[0];
			#80;
		end
		#40;
		dq_in = ~dq_in;
		dm_in = ~dm_in;
		dqs_in = 1'b0;
		// Full burst recovery before any next command.
		#(8 * 160);
	endtask
	task automatic rd(input int rl, input logic [13:0] a, output logic [9:0] s [9]);
		cmd(1'b0, a);
		#(rl * 160 - 40);
		for (int i = 0; i < 9; i++) begin
			s[i] = {dqs_out, dq_oe, dq_out};
			#80;
		end
	endtask
endmodule // dbt_ctl

//--- inc/dbt_lnk_if.sv
// Sampled link pins and edge strobes passed from the synchroniser to the core.
`timescale 1ns/100ps
interface dbt_lnk_if;
	logic ck_rise;
	logic ck_fall;
	logic cmd_rd;
	logic cmd_wr;
	logic [dbt_pkg::BA_W-1:0] ba;
	logic [dbt_pkg::ADDR_W-1:0] addr;
	logic [dbt_pkg::DQ_W-1:0] dq;
	logic dm;
	logic dqs;
	modport src (output ck_rise, ck_fall, cmd_rd, cmd_wr, ba, addr, dq, dm, dqs);
	modport dst (input ck_rise, ck_fall, cmd_rd, cmd_wr, ba, addr, dq, dm, dqs);
endinterface

//--- inc/dbt_pkg.sv
// Constants, register map and types for the burst timing engine.
package dbt_pkg;
	localparam int DQ_W = 8;
	localparam int BA_W = 3;
	localparam int ADDR_W = 14;
	localparam int COL_W = 10;
	localparam int BC_BIT = 12;
	localparam int LAT_W = 5;
	localparam int LAT_MAX = 32;
	localparam int REG_AW = 8;
	localparam int PIN_W = 1 + 4 + BA_W + ADDR_W + DQ_W + 1 + 1;

	// Register offsets.
	localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] REG_STAT = 8'h04;

	// Control register fields.
	localparam int CTRL_BM_LSB = 0;
	localparam int CTRL_TDQS = 2;
	localparam int CTRL_CL_LSB = 4;
	localparam int CTRL_CWL_LSB = 8;
	localparam int CTRL_AL_LSB = 12;
	localparam logic [31:0] CTRL_RST = 32'h0000_0551;

	// Status register fields.
	localparam int STAT_VIOL = 0;
	localparam int STAT_WR_BUSY = 1;
	localparam int STAT_RD_BUSY = 2;
	localparam int STAT_CNT_LSB = 8;

	// Burst mode field encodings.
	localparam logic [1:0] BM_FIXED8 = 2'h0;
	localparam logic [1:0] BM_OTF = 2'h1;
	localparam logic [1:0] BM_FIXED4 = 2'h2;

	// Additive latency selections.
	localparam logic [1:0] AL_ZERO = 2'h0;
	localparam logic [1:0] AL_CL1 = 2'h1;
	localparam logic [1:0] AL_CL2 = 2'h2;

	// Link edges per burst: the end lands on the rise at RL+4 or RL+2.
	localparam logic [3:0] BL8_EDGES = 4'h8;
	localparam logic [3:0] BC4_EDGES = 4'h4;

	// Read-to-precharge minimum for reference by the far side.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TRTP_MIN_PS = 7500;
	localparam int TRTP_MIN_NCK = 4;
	localparam int TRTP_CYC = (TRTP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic {ENG_IDLE, ENG_BURST} dbt_eng_t;
endpackage
